//--- design/scog_top.sv
`timescale 1ns/100ps
module scog_top
    import scog_pkg::*;
#(
    parameter int SHUT_CYCLES  = SHUT_CYC,
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter int SMART_COUNT  = SMART_LEVEL,
    parameter int DEAD_CYCLES  = DEAD_CYC
) (
    input  wire logic       i_clk,              // System clock, 20 MHz
    input  wire logic       i_rst,              // Synchronous reset, active high
    input  wire logic       i_ce,               // Clock enable, freezes state when low
    input  wire logic       i_reg_wr,           // Register write strobe
    input  wire logic [7:0] i_reg_addr,         // Register address
    input  wire logic [7:0] i_reg_wdata,        // Register write data
    output logic      [7:0] o_reg_rdata,        // Registered read data
    input  wire logic [1:0] i_hs_req,           // High-side switch requested, per channel
    input  wire logic [1:0] i_ls_req,           // Low-side switch requested, per channel
    input  wire logic [1:0] i_pushpull,         // Channel runs push-pull
    input  wire logic [1:0] i_ovl,              // Channel in current limit
    input  wire logic [1:0] i_short,            // Channel short circuit
    output logic      [1:0] o_hs_on,            // High-side switch on
    output logic      [1:0] o_ls_on,            // Low-side switch on
    output logic      [1:0] o_excite,           // Excitation current on
    output logic      [1:0] o_fast_drive,       // High speed drive selected
    output logic      [1:0] o_overload_flag_n,  // Overload flags, low on overload
    output logic            o_diagnostic_out_n  // Diagnostic output, low on fault
);
    localparam int DW = $clog2(DEAD_CYCLES + 1);

    logic [7:0]    ch_cfg_reg [2];
    logic [7:0]    ch_cfg_next [2];
    logic [7:0]    prot_cfg_reg, prot_cfg_next;
    logic [7:0]    diag_cfg_reg, diag_cfg_next;
    logic [7:0]    rdata_reg, rdata_next;

    logic [1:0]    hs_reg, hs_next;
    logic [1:0]    ls_reg, ls_next;
    logic [DW-1:0] dead_reg [2];
    logic [DW-1:0] dead_next [2];
    logic [7:0]    exc_cnt_reg [2];
    logic [7:0]    exc_cnt_next [2];
    logic [1:0]    exc_reg, exc_next;
    logic          diag_n_reg, diag_n_next;

    logic [1:0]    guard_off;
    logic [1:0]    flag_n;
    logic [1:0]    excite_enable;
    logic [1:0]    excite_duration;
    logic [1:0]    fast_drive;
    logic          smart_overload_select;
    logic          overload_diag_mask;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            excite_enable[c]   = ch_cfg_reg[c][BIT_EXCITE_EN];   // R1
            excite_duration[c] = ch_cfg_reg[c][BIT_EXCITE_DUR];  // R2
            fast_drive[c]      = ch_cfg_reg[c][BIT_FAST_DRIVE];  // R3
        end
        smart_overload_select = prot_cfg_reg[BIT_SMART_SELECT];  // R7
        overload_diag_mask    = diag_cfg_reg[BIT_DIAG_MASK];     // R12
    end

    // Register file: undefined bits are not stored and read back as zero
    always_comb begin
        ch_cfg_next[0] = ch_cfg_reg[0];
        ch_cfg_next[1] = ch_cfg_reg[1];
        prot_cfg_next  = prot_cfg_reg;
        diag_cfg_next  = diag_cfg_reg;
        if (i_reg_wr) begin
            if (i_reg_addr == ADDR_CH1_CFG) begin
                ch_cfg_next[0] = i_reg_wdata & CH_CFG_MASK;
            end else if (i_reg_addr == ADDR_CH2_CFG) begin
                ch_cfg_next[1] = i_reg_wdata & CH_CFG_MASK;
            end else if (i_reg_addr == ADDR_PROT_CFG) begin
                prot_cfg_next = i_reg_wdata & PROT_CFG_MASK;
            end else if (i_reg_addr == ADDR_DIAG_CFG) begin
                diag_cfg_next = i_reg_wdata & DIAG_CFG_MASK;
            end
        end
        if (i_reg_addr == ADDR_CH1_CFG) begin
            rdata_next = ch_cfg_reg[0];
        end else if (i_reg_addr == ADDR_CH2_CFG) begin
            rdata_next = ch_cfg_reg[1];
        end else if (i_reg_addr == ADDR_PROT_CFG) begin
            rdata_next = prot_cfg_reg;
        end else if (i_reg_addr == ADDR_DIAG_CFG) begin
            rdata_next = diag_cfg_reg;
        end else if (i_reg_addr == ADDR_STATUS) begin
            rdata_next = {6'h00, flag_n};
        end else begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ch_cfg_reg[0] <= CH_CFG_RESET;                                   // R1
            ch_cfg_reg[1] <= CH_CFG_RESET;                                   // R10
            prot_cfg_reg  <= PROT_CFG_RESET;                                 // R7
            diag_cfg_reg  <= DIAG_CFG_RESET;                                 // R12
            rdata_reg     <= 8'h00;
        end else if (i_ce) begin
            ch_cfg_reg[0] <= ch_cfg_next[0];
            ch_cfg_reg[1] <= ch_cfg_next[1];
            prot_cfg_reg  <= prot_cfg_next;
            diag_cfg_reg  <= diag_cfg_next;
            rdata_reg     <= rdata_next;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_guard
        scog_guard #(
            .SHUT_CYCLES  (SHUT_CYCLES),
            .RETRY_CYCLES (RETRY_CYCLES),
            .SMART_COUNT  (SMART_COUNT)
        ) u_guard (
            .i_clk    (i_clk),
            .i_rst    (i_rst),
            .i_ce     (i_ce),
            .i_smart  (smart_overload_select),
            .i_ratio  (ch_cfg_reg[g][BIT_RATIO_LSB +: 2]),
            .i_ovl    (i_ovl[g]),
            .i_short  (i_short[g]),
            .o_off    (guard_off[g]),
            .o_flag_n (flag_n[g])
        );
    end

    // Drive stage: in push-pull mode a switch may only close once the other has been open for the
    // dead time; both requested at once is read as high-side only
    always_comb begin
        logic want_hs;
        logic want_ls;
        logic was_on;
        want_hs = 1'b0;
        want_ls = 1'b0;
        was_on  = 1'b0;
        for (int c = 0; c < 2; c++) begin
            want_hs = i_hs_req[c] && !guard_off[c];                          // R5
            want_ls = i_ls_req[c] && !i_hs_req[c] && !guard_off[c];
            if (i_pushpull[c]) begin
                hs_next[c] = want_hs && (hs_reg[c] || (!ls_reg[c] && dead_reg[c] == '0)); // R4
                ls_next[c] = want_ls && (ls_reg[c] || (!hs_reg[c] && dead_reg[c] == '0)); // R4
            end else begin
                hs_next[c] = want_hs;
                ls_next[c] = want_ls;
            end
            if ((hs_reg[c] && !hs_next[c]) || (ls_reg[c] && !ls_next[c])) begin
                dead_next[c] = DW'(DEAD_CYCLES);                             // R4
            end else if (dead_reg[c] != '0) begin
                dead_next[c] = dead_reg[c] - 1'b1;
            end else begin
                dead_next[c] = dead_reg[c];
            end
            was_on = hs_reg[c] || ls_reg[c];
            if (!excite_enable[c]) begin
                exc_cnt_next[c] = 8'h00;
            end else if ((hs_next[c] || ls_next[c]) && !was_on) begin
                exc_cnt_next[c] = excite_cycles(excite_duration[c]);         // R15
            end else if (exc_cnt_reg[c] != 8'h00) begin
                exc_cnt_next[c] = exc_cnt_reg[c] - 8'h01;
            end else begin
                exc_cnt_next[c] = exc_cnt_reg[c];
            end
            exc_next[c] = (exc_cnt_next[c] != 8'h00);                        // R2
        end
        // Overload flags reach the pin only while the mask bit allows it
        diag_n_next = !(overload_diag_mask && (flag_n != 2'h3));             // R12
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hs_reg          <= 2'h0;
            ls_reg          <= 2'h0;
            dead_reg[0]     <= '0;
            dead_reg[1]     <= '0;
            exc_cnt_reg[0]  <= 8'h00;
            exc_cnt_reg[1]  <= 8'h00;
            exc_reg         <= 2'h0;
            diag_n_reg      <= 1'b1;
        end else if (i_ce) begin
            hs_reg          <= hs_next;
            ls_reg          <= ls_next;
            dead_reg[0]     <= dead_next[0];
            dead_reg[1]     <= dead_next[1];
            exc_cnt_reg[0]  <= exc_cnt_next[0];
            exc_cnt_reg[1]  <= exc_cnt_next[1];
            exc_reg         <= exc_next;
            diag_n_reg      <= diag_n_next;
        end
    end

    assign o_reg_rdata        = rdata_reg;
    assign o_hs_on            = hs_reg;
    assign o_ls_on            = ls_reg;
    assign o_excite           = exc_reg;
    assign o_fast_drive       = fast_drive;                                  // R3
    assign o_overload_flag_n  = flag_n;
    assign o_diagnostic_out_n = diag_n_reg;

    for (genvar a = 0; a < 2; a++) begin : g_check
        a_no_overlap: assert property (@(posedge i_clk) disable iff (i_rst) // R4
            !(hs_reg[a] && ls_reg[a]))
            else $error("both switches of a channel are on");
        a_dead_gap: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R4
            i_pushpull[a] && !hs_reg[a] && hs_next[a] |-> dead_reg[a] == '0 && !ls_reg[a])
            else $error("high-side closed inside the dead time");
        a_off_opens: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R5
            guard_off[a] |=> !hs_reg[a] && !ls_reg[a])
            else $error("switch stayed on during shutdown");
        a_excite_start: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R15
            excite_enable[a] && !hs_reg[a] && !ls_reg[a] && (hs_next[a] || ls_next[a])
            |=> exc_reg[a] && exc_cnt_reg[a] == excite_cycles($past(excite_duration[a])))
            else $error("excitation pulse did not start at switch-on");
        a_excite_end: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R2
            exc_cnt_reg[a] == 8'h01 && (hs_reg[a] || ls_reg[a] || !(hs_next[a] || ls_next[a]))
            |=> !exc_reg[a])
            else $error("excitation pulse ran past its length");
        a_excite_off: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R1
            !excite_enable[a] |=> !exc_reg[a])
            else $error("excitation on while disabled");
    end

    a_reset_values: assert property (@(posedge i_clk) // R10
        $past(i_rst) |-> smart_overload_select && overload_diag_mask && excite_enable == 2'h0
            && fast_drive == 2'h0 && excite_duration == 2'h0
            && ch_cfg_reg[0][BIT_RATIO_LSB +: 2] == 2'h2)
        else $error("configuration reset values wrong");
    a_diag_masked: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R12
        !overload_diag_mask |=> o_diagnostic_out_n)
        else $error("masked overload reached the diagnostic output");
    a_diag_shows: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R12
        overload_diag_mask && flag_n != 2'h3 |=> !o_diagnostic_out_n)
        else $error("overload not shown on the diagnostic output");
endmodule

//--- design/scog_pkg.sv
// Overview of operation
// [R1] Each channel has an excitation enable at bit 3 of 0x03/0x04, reset off.
// [R2] Bit 6 picks excitation length: 0 gives 2.5 us, 1 gives 7.5 us.
// [R3] Bit 7 picks normal (0, reset) or high speed drive (1) per channel.
// [R4] Push-pull channels keep a dead time between one switch off and the other on.
// [R5] A short circuit turns that channel's switches off for 50 ms.
// [R6] Normal mode trips only after overload lasts longer than 160 us.
// [R7] Bit 6 of 0x06, reset 1, selects smart (1) or normal (0) detection.
// [R8] Smart mode integrator counts up each clock while its channel is overloaded.
// [R9] Without overload the integrator counts down once per ratio-set waiting interval.
// [R10] Ratio field bits 5:4: 00=1:4, 01=1:8, 10=1:10, 11=1:15, reset 10.
// [R11] Integrator at overload level turns channel off 50 ms and clears its flag.
// [R12] Mask bit 4 of 0x08, reset 1, gates cleared flags onto diagnostic output.
// [R13] After shutdown, switches retry with flag held; 1 ms clean sets the flag again.
// [R14] Threshold and down-count interval make tolerated on/off ratio match setting.
// [R15] Enabled excitation pulse starts at each switch-on and lasts the chosen time.
package scog_pkg;
    localparam int CLK_PERIOD_NS = 50;

    localparam logic [7:0] ADDR_CH1_CFG  = 8'h03;
    localparam logic [7:0] ADDR_CH2_CFG  = 8'h04;
    localparam logic [7:0] ADDR_PROT_CFG = 8'h06;
    localparam logic [7:0] ADDR_DIAG_CFG = 8'h08;
    localparam logic [7:0] ADDR_STATUS   = 8'h0A;

    localparam int BIT_FAST_DRIVE   = 7;
    localparam int BIT_EXCITE_DUR   = 6;
    localparam int BIT_RATIO_LSB    = 4;
    localparam int BIT_EXCITE_EN    = 3;
    localparam int BIT_SMART_SELECT = 6;
    localparam int BIT_DIAG_MASK    = 4;

    localparam logic [7:0] CH_CFG_RESET   = 8'h20;
    localparam logic [7:0] CH_CFG_MASK    = 8'hF8;
    localparam logic [7:0] PROT_CFG_RESET = 8'h40;
    localparam logic [7:0] PROT_CFG_MASK  = 8'h40;
    localparam logic [7:0] DIAG_CFG_RESET = 8'h10;
    localparam logic [7:0] DIAG_CFG_MASK  = 8'h10;

    localparam int EXC_SHORT_NS  = 2500;
    localparam int EXC_LONG_NS   = 7500;
    localparam int EXC_SHORT_CYC = (EXC_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXC_LONG_CYC  = (EXC_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEAD_NS       = 500;
    localparam int DEAD_CYC      = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NORMAL_US     = 160;
    localparam int NORMAL_CYC    = NORMAL_US * 1000 / CLK_PERIOD_NS;
    localparam int SHUT_MS       = 50;
    localparam int SHUT_CYC      = SHUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RETRY_MS      = 1;
    localparam int RETRY_CYC     = RETRY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SMART_LEVEL   = NORMAL_CYC;

    localparam logic [3:0] RATIO_WAIT_4  = 4'h4;
    localparam logic [3:0] RATIO_WAIT_8  = 4'h8;
    localparam logic [3:0] RATIO_WAIT_10 = 4'hA;
    localparam logic [3:0] RATIO_WAIT_15 = 4'hF;

    typedef enum logic [1:0] {GUARD_RUN, GUARD_SHUT, GUARD_RETRY} scog_guard_t;

    // Cycles without overload per integrator down-step
    function automatic logic [3:0] ratio_wait(input logic [1:0] ratio);
        logic [3:0] w;
        if (ratio == 2'h0) begin
            w = RATIO_WAIT_4;
        end else if (ratio == 2'h1) begin
            w = RATIO_WAIT_8;
        end else if (ratio == 2'h2) begin
            w = RATIO_WAIT_10;
        end else begin
            w = RATIO_WAIT_15;
        end
        return w;
    endfunction

    function automatic logic [7:0] excite_cycles(input logic long_pulse);
        return long_pulse ? 8'(EXC_LONG_CYC) : 8'(EXC_SHORT_CYC);
    endfunction
endpackage

//--- design/scog_guard.sv
`timescale 1ns/100ps
module scog_guard
    import scog_pkg::*;
#(
    parameter int SHUT_CYCLES  = SHUT_CYC,
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter int SMART_COUNT  = SMART_LEVEL
) (
    input  wire logic       i_clk,    // System clock
    input  wire logic       i_rst,    // Synchronous reset
    input  wire logic       i_ce,     // Clock enable
    input  wire logic       i_smart,  // Smart detection selected
    input  wire logic [1:0] i_ratio,  // Overload ratio setting
    input  wire logic       i_ovl,    // Switch in current limit
    input  wire logic       i_short,  // Short circuit detected
    output logic            o_off,    // Switches forced off
    output logic            o_flag_n  // Overload flag, low on overload
);
    localparam int LONGEST = (SHUT_CYCLES > RETRY_CYCLES) ? SHUT_CYCLES : RETRY_CYCLES;
    localparam int TW = $clog2(LONGEST + 1);
    localparam int NW = $clog2(NORMAL_CYC + 1);
    localparam int IW = $clog2(SMART_COUNT + 1);

    scog_guard_t   state_reg, state_next;
    logic [TW-1:0] timer_reg, timer_next;
    logic [NW-1:0] filt_reg,  filt_next;
    logic [IW-1:0] integ_reg, integ_next;
    logic [3:0]    wait_reg,  wait_next;
    logic          flag_n_reg, flag_n_next;
    logic          trip;

    always_comb begin
        trip = i_short                                                       // R5
            | (!i_smart && i_ovl && filt_reg == NW'(NORMAL_CYC))            // R6
            | (i_smart && integ_reg >= IW'(SMART_COUNT));                   // R11
        state_next  = state_reg;
        timer_next  = timer_reg;
        flag_n_next = flag_n_reg;
        filt_next   = i_ovl ? ((filt_reg == NW'(NORMAL_CYC)) ? filt_reg : filt_reg + 1'b1)
                            : '0;
        integ_next  = integ_reg;
        wait_next   = wait_reg;
        if (i_ovl) begin
            wait_next = '0;
            if (integ_reg < IW'(SMART_COUNT)) begin
                integ_next = integ_reg + 1'b1;                               // R8
            end
        end else if (wait_reg >= ratio_wait(i_ratio) - 4'h1) begin
            // One down-step per N clean cycles tolerates a 1:N on/off ratio
            wait_next = '0;                                                  // R14
            if (integ_reg != '0) begin
                integ_next = integ_reg - 1'b1;                               // R9
            end
        end else begin
            wait_next = wait_reg + 4'h1;
        end
        case (state_reg)
            GUARD_RUN: begin
                if (trip) begin
                    state_next  = GUARD_SHUT;
                    timer_next  = '0;
                    flag_n_next = 1'b0;                                      // R11
                end
            end
            GUARD_SHUT: begin
                filt_next  = '0;
                integ_next = '0;
                wait_next  = '0;
                if (timer_reg == TW'(SHUT_CYCLES - 1)) begin
                    state_next = GUARD_RETRY;                                // R13
                    timer_next = '0;
                end else begin
                    timer_next = timer_reg + 1'b1;
                end
            end
            GUARD_RETRY: begin
                if (trip) begin
                    state_next = GUARD_SHUT;
                    timer_next = '0;
                end else if (timer_reg == TW'(RETRY_CYCLES - 1)) begin
                    state_next  = GUARD_RUN;
                    flag_n_next = 1'b1;                                      // R13
                end else begin
                    timer_next = timer_reg + 1'b1;
                end
            end
            default: begin
                state_next = GUARD_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg  <= GUARD_RUN;
            timer_reg  <= '0;
            filt_reg   <= '0;
            integ_reg  <= '0;
            wait_reg   <= '0;
            flag_n_reg <= 1'b1;
        end else if (i_ce) begin
            state_reg  <= state_next;
            timer_reg  <= timer_next;
            filt_reg   <= filt_next;
            integ_reg  <= integ_next;
            wait_reg   <= wait_next;
            flag_n_reg <= flag_n_next;
        end
    end

    assign o_off    = (state_reg == GUARD_SHUT);
    assign o_flag_n = flag_n_reg;

    a_short_trips: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R5
        state_reg == GUARD_RUN && i_short |=> o_off && !o_flag_n)
        else $error("short circuit did not shut the channel");
    a_normal_filter: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R6
        state_reg == GUARD_RUN && !i_smart && !i_short && filt_reg < NW'(NORMAL_CYC)
        |=> state_reg == GUARD_RUN)
        else $error("normal mode tripped before the filter time");
    a_integ_step: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R8
        state_reg == GUARD_RUN && i_ovl && integ_reg < IW'(SMART_COUNT)
        |=> integ_reg == $past(integ_reg) + 1'b1)
        else $error("integrator missed an up step");
    a_shut_ends: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R11
        state_reg == GUARD_SHUT && timer_reg == TW'(SHUT_CYCLES - 1)
        |=> state_reg == GUARD_RETRY && !o_off && !o_flag_n)
        else $error("shutdown did not end in retry");
    a_retry_release: assert property (@(posedge i_clk) disable iff (i_rst || !i_ce) // R13
        state_reg == GUARD_RETRY && !trip && timer_reg == TW'(RETRY_CYCLES - 1)
        |=> state_reg == GUARD_RUN && o_flag_n)
        else $error("flag not restored after clean retry");
endmodule

//--- bench/scog_load.sv
`timescale 1ns/100ps
module scog_load (
    input  wire logic [1:0] i_hs_on,  // High-side states
    input  wire logic [1:0] i_ls_on,  // Low-side states
    input  wire logic [1:0] i_heavy,  // Load above limit
    input  wire logic [1:0] i_fault,  // Output shorted
    output logic      [1:0] o_ovl,    // Current limit seen
    output logic      [1:0] o_short   // Short seen
);
    // Limit and short only show while a switch conducts
    assign o_ovl   = i_heavy & (i_hs_on | i_ls_on);
    assign o_short = i_fault & (i_hs_on | i_ls_on);
endmodule

//--- bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import scog_pkg::*;
    logic       clk = 1'h0, rst = 1'h1, wr = 1'h0, ce = 1'h1, diag;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [1:0] hs = 2'h0, ls = 2'h0, pp = 2'h0, heavy = 2'h0, fault = 2'h0;
    logic [1:0] hs_on, ls_on, exc, fast, flg, ovl, sht;
    int         fail_count = 0, checks_done = 0, n;
    always #25 clk = ~clk;
    scog_top #(.SHUT_CYCLES(50), .RETRY_CYCLES(20), .SMART_COUNT(16)) uut (
        .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_reg_wr(wr), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_hs_req(hs), .i_ls_req(ls),
        .i_pushpull(pp), .i_ovl(ovl), .i_short(sht), .o_hs_on(hs_on), .o_ls_on(ls_on),
        .o_excite(exc), .o_fast_drive(fast), .o_overload_flag_n(flg),
        .o_diagnostic_out_n(diag));
    scog_load load (.i_hs_on(hs_on), .i_ls_on(ls_on), .i_heavy(heavy), .i_fault(fault),
        .o_ovl(ovl), .o_short(sht));
    task check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'h1;
        @(negedge clk);
        wr = 1'h0;
    endtask
    task rreg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check(rdata, e);
    endtask
    task t_regs;
        rreg(ADDR_CH1_CFG, 8'h20);
        rreg(ADDR_CH2_CFG, 8'h20);
        rreg(ADDR_PROT_CFG, 8'h40);
        rreg(ADDR_DIAG_CFG, 8'h10);
        rreg(8'h05, 8'h00);
        // A write while the clock enable is low must not land
        ce = 1'h0;
        wreg(ADDR_CH2_CFG, 8'h88);
        ce = 1'h1;
        rreg(ADDR_CH2_CFG, 8'h20);
        wreg(ADDR_CH2_CFG, 8'hFF);
        rreg(ADDR_CH2_CFG, 8'hF8);
        check(fast, 2'h2);
        wreg(ADDR_CH2_CFG, 8'h20);
    endtask
    task count_exc(input logic [7:0] cfg, input int e);
        wreg(ADDR_CH1_CFG, cfg);
        hs = 2'h1;
        n = 0;
        repeat (200) begin
            @(negedge clk);
            n += exc[0];
        end
        check(16'(n), 16'(e));
        hs = 2'h0;
        cyc(3);
    endtask
    task t_dead;
        pp = 2'h1;
        hs = 2'h1;
        cyc(20);
        hs = 2'h0;
        ls = 2'h1;
        n = 0;
        repeat (30) begin
            @(negedge clk);
            n += (hs_on[0] == 1'h0 && ls_on[0] == 1'h0);
        end
        // The switch-off edge loads the counter, so one more open cycle passes
        check(16'(n), 16'(DEAD_CYC + 1));
        ls = 2'h0;
        pp = 2'h0;
    endtask
    task t_normal;
        wreg(ADDR_PROT_CFG, 8'h00);
        hs = 2'h1;
        cyc(5);
        heavy = 2'h1;
        cyc(3000);
        heavy = 2'h0;
        check(flg, 2'h3);
        cyc(5);
        heavy = 2'h1;
        n = 0;
        while (flg[0] === 1'h1 && n < 4000) begin
            @(negedge clk);
            n++;
        end
        check(n >= 3200 && n <= 3203, 1'h1);
        cyc(1);
        check(hs_on[0], 1'h0);
        check(diag, 1'h0);
        heavy = 2'h0;
        cyc(25);
        check({hs_on[0], flg[0]}, 2'h0);
        cyc(30);
        check({hs_on[0], flg[0]}, 2'h2);
        cyc(20);
        check({flg[0], diag}, 2'h3);
    endtask
    task t_short;
        wreg(ADDR_DIAG_CFG, 8'h00);
        fault = 2'h1;
        @(negedge clk);
        fault = 2'h0;
        cyc(2);
        check({hs_on[0], flg[0], diag}, 3'h1);
        rreg(ADDR_STATUS, 8'h02);
        cyc(80);
        check(flg, 2'h3);
        wreg(ADDR_DIAG_CFG, 8'h10);
    endtask
    task t_smart;
        // Ratio 1:4 so a 16-cycle gap sheds four counts
        wreg(ADDR_PROT_CFG, 8'h40);
        wreg(ADDR_CH1_CFG, 8'h00);
        heavy = 2'h1;
        cyc(12);
        heavy = 2'h0;
        cyc(16);
        heavy = 2'h1;
        cyc(7);
        check(flg[0], 1'h1);
        n = 0;
        while (flg[0] === 1'h1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check(n <= 3, 1'h1);
        heavy = 2'h0;
        hs = 2'h0;
        cyc(80);
        check(flg, 2'h3);
    endtask
    initial begin
        cyc(8);
        rst = 1'h0;
        t_regs();
        count_exc(8'h08, EXC_SHORT_CYC);
        count_exc(8'h48, EXC_LONG_CYC);
        t_dead();
        t_normal();
        t_short();
        t_smart();
        summarize();
    end
    initial begin
        #1000000;
        fail_count++;
        summarize();
    end
endmodule
